// ===== rtl/ucc_params.svh
// Offsets, field positions, reset values and timing counts of the
// USB control/config register pair. Included by the package and the core.
`ifndef UCC_PARAMS_SVH
`define UCC_PARAMS_SVH

`define UCC_ADDR_W 12
`define UCC_OFS_CONTROL 12'h000
`define UCC_OFS_CONFIG 12'h004
`define UCC_WORD_ZERO 32'h0000_0000

`define UCC_CTL_LIVE_J_STATE_FLAG 7
`define UCC_CTL_SE0 6
`define UCC_CTL_PACKET_DISABLE 5
`define UCC_CTL_BUSRST 4
`define UCC_CTL_HOST_ENABLE 3
`define UCC_CTL_RESUME 2

`define UCC_CFG_EYE 7
`define UCC_CFG_OEMON 6
`define UCC_CFG_SIDL 4
`define UCC_CFG_LOW_SPEED_DEVICE_ONLY 3
`define UCC_CFG_ASUSP 0

`define UCC_IMPL_TOP 7
`define UCC_IMPL_W 8
`define UCC_CTL_RESET 4'h0
`define UCC_CFG_RESET 5'h00

`define UCC_CLK_PERIOD_PS 4000
`define UCC_LS_EOP_SE0_NS 1333
`define UCC_LS_EOP_J_NS 667
`define UCC_CYC_UP(ns) ((((ns) * 1000) + `UCC_CLK_PERIOD_PS - 1) / `UCC_CLK_PERIOD_PS)
`define UCC_EOP_CNT_W 9
`define UCC_EOP_SE0_CYC `UCC_CYC_UP(`UCC_LS_EOP_SE0_NS)
`define UCC_EOP_J_CYC `UCC_CYC_UP(`UCC_LS_EOP_J_NS)

`endif

// ===== rtl/ucc_pkg.sv
// Types shared by the USB control/config register block.
// Assumes ucc_params.svh is on the include path.
`include "ucc_params.svh"

package ucc_pkg;

	typedef struct packed
	{
		logic packet_disable;
		logic bus_reset_drive;
		logic host_enable;
		logic resume_drive;
	} ucc_ctl_t;

	typedef struct packed
	{
		logic eye_test_enable;
		logic output_enable_monitor;
		logic stop_in_idle;
		logic low_speed_device_only;
		logic auto_suspend_on_sleep;
	} ucc_cfg_t;

	typedef struct packed
	{
		logic dp;
		logic dm;
	} ucc_line_t;

	typedef struct packed
	{
		logic se0;
		logic j;
		logic k;
	} ucc_drive_t;

	typedef enum logic [1:0] {EOP_IDLE, EOP_SE0, EOP_J} ucc_eop_t;

	typedef struct packed
	{
		ucc_ctl_t ctl;
		ucc_cfg_t cfg;
		logic token_busy;
		ucc_line_t sync1;
		ucc_line_t sync2;
		logic host_rst;
		ucc_eop_t eop;
		logic [`UCC_EOP_CNT_W-1:0] eop_cnt;
		logic [31:0] prdata;
		logic pslverr;
	} ucc_state_t;

endpackage

// ===== rtl/ucc_regs.sv
// USB control and configuration registers with live line state,
// reset/resume drive, low-speed EOP tail and mode outputs.
// Assumes an APB master on pclk and a line receiver synchronous-free.
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`include "ucc_params.svh"

module ucc_regs
	import ucc_pkg::*;
(
	// Clock and reset
	input logic pclk,
	input logic presetn,
	// APB slave
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [`UCC_ADDR_W-1:0] paddr,
	input logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Line receiver
	input ucc_line_t line_in,
	// Token engine
	input logic setup_token_rx,
	input logic token_start,
	input logic token_done,
	output logic token_proc_en,
	output logic host_logic_reset,
	// Line drive
	output ucc_drive_t line_drive,
	output logic line_oe,
	output logic oe_monitor_n,
	// Mode and power
	input logic idle_mode,
	input logic sleep_mode,
	input logic suspend_control,
	output logic host_mode,
	output logic eye_test_enable,
	output logic low_speed_device_only,
	output logic module_halt,
	output logic usb_suspend
);

	localparam logic [`UCC_EOP_CNT_W-1:0] SE0_LAST =
		`UCC_EOP_CNT_W'(`UCC_EOP_SE0_CYC - 1);
	localparam logic [`UCC_EOP_CNT_W-1:0] J_LAST =
		`UCC_EOP_CNT_W'(`UCC_EOP_J_CYC - 1);

	ucc_state_t s_q;
	ucc_state_t s_d;

	logic setup_ph;
	logic wr_ph;
	logic sel_ctl;
	logic sel_cfg;
	logic j_now;
	logic se0_now;
	logic busy_bit;
	logic [31:0] ctl_word;
	logic [31:0] cfg_word;

	assign setup_ph = psel && !penable;
	assign wr_ph = psel && penable && pwrite;
	assign sel_ctl = paddr == `UCC_OFS_CONTROL;
	assign sel_cfg = paddr == `UCC_OFS_CONFIG;

	// Low-speed J is the inverse polarity of full-speed J
	assign j_now = s_q.cfg.low_speed_device_only ?
		(s_q.sync2.dm && !s_q.sync2.dp) :
		(s_q.sync2.dp && !s_q.sync2.dm);
	assign se0_now = !s_q.sync2.dp && !s_q.sync2.dm;

	// Bit 5 shares one position between the two modes
	assign busy_bit = s_q.ctl.host_enable ?
		s_q.token_busy : s_q.ctl.packet_disable;

	always_comb
	begin
		ctl_word = `UCC_WORD_ZERO;
		ctl_word[`UCC_CTL_LIVE_J_STATE_FLAG] = j_now;
		ctl_word[`UCC_CTL_SE0] = se0_now;
		ctl_word[`UCC_CTL_PACKET_DISABLE] = busy_bit;
		ctl_word[`UCC_CTL_BUSRST] = s_q.ctl.bus_reset_drive;
		ctl_word[`UCC_CTL_HOST_ENABLE] = s_q.ctl.host_enable;
		ctl_word[`UCC_CTL_RESUME] = s_q.ctl.resume_drive;
		cfg_word = `UCC_WORD_ZERO;
		cfg_word[`UCC_CFG_EYE] = s_q.cfg.eye_test_enable;
		cfg_word[`UCC_CFG_OEMON] = s_q.cfg.output_enable_monitor;
		cfg_word[`UCC_CFG_SIDL] = s_q.cfg.stop_in_idle;
		cfg_word[`UCC_CFG_LOW_SPEED_DEVICE_ONLY] = s_q.cfg.low_speed_device_only;
		cfg_word[`UCC_CFG_ASUSP] = s_q.cfg.auto_suspend_on_sleep;
	end

	always_comb
	begin
		s_d = s_q;
		s_d.host_rst = 1'b0;

		// Two-stage synchroniser, first stage feeds only the second
		s_d.sync1 = line_in;
		s_d.sync2 = s_q.sync1;

		// Token busy only has meaning in host mode; start wins over done
		if (!s_q.ctl.host_enable)
		begin
			s_d.token_busy = 1'b0;
		end
		else if (token_start)
		begin
			s_d.token_busy = 1'b1;
		end
		else if (token_done)
		begin
			s_d.token_busy = 1'b0;
		end

		// Low-speed EOP tail: SE0 for two bit times, then J for one
		unique case (s_q.eop)
			EOP_IDLE:
			begin
				s_d.eop_cnt = s_q.eop_cnt;
			end
			EOP_SE0:
			begin
				if (s_q.eop_cnt != '0)
				begin
					s_d.eop_cnt = s_q.eop_cnt - 1'b1;
				end
				else
				begin
					s_d.eop = EOP_J;
					s_d.eop_cnt = J_LAST;
				end
			end
			EOP_J:
			begin
				if (s_q.eop_cnt != '0)
				begin
					s_d.eop_cnt = s_q.eop_cnt - 1'b1;
				end
				else
				begin
					s_d.eop = EOP_IDLE;
				end
			end
			default:
			begin
				s_d.eop = EOP_IDLE;
			end
		endcase

		// Register writes take effect in the access phase
		if (wr_ph && sel_ctl)
		begin
			s_d.ctl.bus_reset_drive = pwdata[`UCC_CTL_BUSRST];
			s_d.ctl.host_enable = pwdata[`UCC_CTL_HOST_ENABLE];
			s_d.ctl.resume_drive = pwdata[`UCC_CTL_RESUME];
			// In host mode bit 5 is the read-only busy view
			if (!s_q.ctl.host_enable)
			begin
				s_d.ctl.packet_disable = pwdata[`UCC_CTL_PACKET_DISABLE];
			end
			if (s_q.ctl.host_enable && s_q.ctl.resume_drive &&
				!pwdata[`UCC_CTL_RESUME])
			begin
				s_d.eop = EOP_SE0;
				s_d.eop_cnt = SE0_LAST;
			end
		end
		if (wr_ph && sel_cfg)
		begin
			s_d.cfg.eye_test_enable = pwdata[`UCC_CFG_EYE];
			s_d.cfg.output_enable_monitor = pwdata[`UCC_CFG_OEMON];
			s_d.cfg.stop_in_idle = pwdata[`UCC_CFG_SIDL];
			s_d.cfg.low_speed_device_only = pwdata[`UCC_CFG_LOW_SPEED_DEVICE_ONLY];
			s_d.cfg.auto_suspend_on_sleep = pwdata[`UCC_CFG_ASUSP];
		end

		// SETUP arrival beats a software clear in the same cycle
		if (setup_token_rx && !s_q.ctl.host_enable)
		begin
			s_d.ctl.packet_disable = 1'b1;
		end

		// Any host-enable toggle flushes host state
		if (s_d.ctl.host_enable != s_q.ctl.host_enable)
		begin
			s_d.host_rst = 1'b1;
			s_d.token_busy = 1'b0;
			s_d.eop = EOP_IDLE;
			s_d.eop_cnt = '0;
		end

		// Read data is captured in setup so it is stable in access
		if (setup_ph)
		begin
			s_d.pslverr = !(sel_ctl || sel_cfg);
			if (pwrite)
			begin
				s_d.prdata = `UCC_WORD_ZERO;
			end
			else if (sel_ctl)
			begin
				s_d.prdata = ctl_word;
			end
			else if (sel_cfg)
			begin
				s_d.prdata = cfg_word;
			end
			else
			begin
				s_d.prdata = `UCC_WORD_ZERO;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_q.ctl <= `UCC_CTL_RESET;
			s_q.cfg <= `UCC_CFG_RESET;
			s_q.token_busy <= 1'b0;
			s_q.sync1 <= '0;
			s_q.sync2 <= '0;
			s_q.host_rst <= 1'b0;
			s_q.eop <= EOP_IDLE;
			s_q.eop_cnt <= '0;
			s_q.prdata <= `UCC_WORD_ZERO;
			s_q.pslverr <= 1'b0;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// Zero wait states; every access ends one cycle after setup
	assign pready = 1'b1;
	assign prdata = s_q.prdata;
	assign pslverr = s_q.pslverr;

	assign host_mode = s_q.ctl.host_enable;
	assign host_logic_reset = s_q.host_rst;
	assign eye_test_enable = s_q.cfg.eye_test_enable;
	assign low_speed_device_only = s_q.cfg.low_speed_device_only;
	assign module_halt = s_q.cfg.stop_in_idle && idle_mode;
	assign usb_suspend = suspend_control ||
		(s_q.cfg.auto_suspend_on_sleep && sleep_mode);
	assign token_proc_en = (s_q.ctl.host_enable || !s_q.ctl.packet_disable) &&
		!module_halt;

	// Bus reset overrides resume K; EOP tail only follows resume
	assign line_drive.se0 = s_q.ctl.bus_reset_drive || s_q.eop == EOP_SE0;
	assign line_drive.k = s_q.ctl.resume_drive && !s_q.ctl.bus_reset_drive;
	assign line_drive.j = s_q.eop == EOP_J && !s_q.ctl.bus_reset_drive;
	assign line_oe = line_drive.se0 || line_drive.j || line_drive.k;
	assign oe_monitor_n = !(s_q.cfg.output_enable_monitor && line_oe);

	chk_live_j_state_flag_read: assert property (@(posedge pclk) disable iff (!presetn)
		(setup_ph && !pwrite && sel_ctl) |=> prdata[`UCC_CTL_LIVE_J_STATE_FLAG] == $past(j_now))
		else $error("J state flag read mismatch");

	chk_se0_read: assert property (@(posedge pclk) disable iff (!presetn)
		(setup_ph && !pwrite && sel_ctl) |=> prdata[`UCC_CTL_SE0] == $past(se0_now))
		else $error("SE0 flag read mismatch");

	chk_setup_sets_packet_disable: assert property (@(posedge pclk) disable iff (!presetn)
		(setup_token_rx && !s_q.ctl.host_enable && !(wr_ph && sel_ctl)) |=> s_q.ctl.packet_disable)
		else $error("SETUP did not set packet disable");

	chk_busy_view: assert property (@(posedge pclk) disable iff (!presetn)
		(setup_ph && !pwrite && sel_ctl && s_q.ctl.host_enable)
		|=> prdata[`UCC_CTL_PACKET_DISABLE] == $past(s_q.token_busy))
		else $error("Token busy read mismatch");

	chk_reset_drive: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_ph && sel_ctl && pwdata[`UCC_CTL_BUSRST]) |=> (line_drive.se0 && line_oe))
		else $error("Bus reset not driven after write");

	chk_host_toggle: assert property (@(posedge pclk) disable iff (!presetn)
		$changed(s_q.ctl.host_enable) |-> (host_logic_reset && !s_q.token_busy))
		else $error("Host toggle did not reset host logic");

	chk_resume_k: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_ph && sel_ctl && pwdata[`UCC_CTL_RESUME] && !pwdata[`UCC_CTL_BUSRST])
		|=> line_drive.k)
		else $error("Resume K not driven");

	chk_eop_tail: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_ph && sel_ctl && s_q.ctl.host_enable && s_q.ctl.resume_drive &&
		pwdata[`UCC_CTL_HOST_ENABLE] && !pwdata[`UCC_CTL_RESUME] && !pwdata[`UCC_CTL_BUSRST])
		|=> (line_drive.se0 && !line_drive.k) [*8])
		else $error("Low-speed EOP did not follow resume");

	chk_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && penable) |-> prdata[31:`UCC_IMPL_W] == '0)
		else $error("Unimplemented bits not zero");

	chk_oemon_idle: assert property (@(posedge pclk) disable iff (!presetn)
		!s_q.cfg.output_enable_monitor |-> oe_monitor_n)
		else $error("OE monitor active while disabled");

	chk_auto_suspend: assert property (@(posedge pclk) disable iff (!presetn)
		(s_q.cfg.auto_suspend_on_sleep && sleep_mode) |-> usb_suspend)
		else $error("Auto suspend missing in sleep");

	chk_busy_set: assert property (@(posedge pclk) disable iff (!presetn)
		(s_q.ctl.host_enable && token_start && !(wr_ph && sel_ctl)) |=> s_q.token_busy)
		else $error("Token start did not set busy");

	chk_eop_j_phase: assert property (@(posedge pclk) disable iff (!presetn)
		(s_q.eop == EOP_SE0 && s_q.eop_cnt == '0 && !s_q.ctl.bus_reset_drive && !(wr_ph && sel_ctl))
		|=> (line_drive.j && !line_drive.se0))
		else $error("EOP J phase did not follow SE0");

	chk_idle_halt: assert property (@(posedge pclk) disable iff (!presetn)
		(s_q.cfg.stop_in_idle && idle_mode) |-> (module_halt && !token_proc_en))
		else $error("Module ran while stopped in idle");

endmodule

// ===== bench/ucc_far_port.sv
// Far-side USB port model: resolves the D+/D- pair from the block's drive
// and the far party's own line state. Pull-ups make an undriven pair read J.
`timescale 1ns/1ps

module ucc_far_port
	import ucc_pkg::*;
(
	// Block side
	input ucc_drive_t drv,
	input logic oe,
	input logic ls,
	// Far party state: 0 J, 1 K, 2 SE0
	input logic [1:0] far_st,
	output ucc_line_t line
);
	logic [1:0] j_lvl;

	// Low-speed swaps the J polarity
	assign j_lvl = ls ? 2'h1 : 2'h2;

	always_comb
	begin
		if (oe)
			line = drv.se0 ? 2'h0 : (drv.k ? ~j_lvl : j_lvl);
		else
			line = (far_st == 2'h2) ? 2'h0 : ((far_st == 2'h1) ? ~j_lvl : j_lvl);
	end
endmodule

// ===== bench/test_ucc_regs.sv
// Self-checking bench for the USB control/config register pair.
// Assumes the package and the far-side port model are compiled first.
`timescale 1ns/1ps
`include "ucc_params.svh"

module test_ucc_regs
	import ucc_pkg::*;
;
	localparam logic [11:0] CTL = `UCC_OFS_CONTROL;
	localparam logic [11:0] CFG = `UCC_OFS_CONFIG;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic setup_token_rx, token_start, token_done, token_proc_en, host_logic_reset;
	logic line_oe, oe_monitor_n, idle_mode, sleep_mode, suspend_control, host_mode;
	logic eye_test_enable, low_speed_device_only, module_halt, usb_suspend;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, d, r;
	logic [1:0] far_st;
	ucc_line_t line_in;
	ucc_drive_t line_drive;
	integer n_fail, n_checks, cyc, seed, i, n, k;

	ucc_regs i_ucc_regs (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .line_in, .setup_token_rx, .token_start, .token_done, .token_proc_en,
		.host_logic_reset, .line_drive, .line_oe, .oe_monitor_n, .idle_mode, .sleep_mode,
		.suspend_control, .host_mode, .eye_test_enable, .low_speed_device_only, .module_halt,
		.usb_suspend);

	ucc_far_port i_ucc_far_port (.drv(line_drive), .oe(line_oe), .ls(low_speed_device_only),
		.far_st(far_st), .line(line_in));

	initial
	begin
		pclk = 1'h0;
		forever #2 pclk = ~pclk;
	end

	function automatic logic [31:0] ectl(input logic jf, input logic se, input logic [3:0] v);
		return {24'h00_0000, jf, se, v, 2'h0};
	endfunction

	task end_sim;
		if (n_fail == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Idle cycle first, so psel is never lowered and raised in one step
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task rd_chk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'h0, a, 32'h0000_0000);
		chk(rd, exp);
	endtask

	task pulses(output integer c);
		c = 0;
		repeat (4)
		begin
			#1;
			if (host_logic_reset === 1'h1)
				c++;
			@(posedge pclk);
		end
	endtask

	// Length of one line-drive phase, waiting briefly for it to begin
	task span(input integer w, output integer c);
		c = 0;
		#1;
		for (k = 0; k < 3 && line_drive[w] !== 1'h1; k++)
		begin
			@(posedge pclk);
			#1;
		end
		while (line_drive[w] === 1'h1 && c < 1000)
		begin
			c++;
			@(posedge pclk);
			#1;
		end
	endtask

	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			n_fail++;
			end_sim;
		end
	end

	initial
	begin
		{cyc, n_fail, n_checks} = '0;
		seed = 32'hcfc7_dbe1;
		{presetn, psel, penable, pwrite, paddr, pwdata, far_st} = '0;
		{setup_token_rx, token_start, token_done, idle_mode, sleep_mode, suspend_control} = '0;
		repeat (16) @(posedge pclk);
		presetn <= 1'h1;
		repeat (3) @(posedge pclk);
		rd_chk(CTL, 32'h0000_0080);
		rd_chk(CFG, 32'h0000_0000);
		chk({31'h0, err}, 32'h0000_0000);
		apb(1'h1, 12'h008, 32'hffff_ffff);
		chk({31'h0, err}, 32'h0000_0001);
		rd_chk(CFG, 32'h0000_0000);
		for (i = 0; i < 24; i++)
		begin
			d = $random(seed);
			r = $random(seed);
			idle_mode <= r[0];
			sleep_mode <= r[1];
			suspend_control <= r[2];
			apb(1'h1, CFG, d);
			#1;
			chk({eye_test_enable, low_speed_device_only, module_halt, usb_suspend},
				{d[7], d[3], d[4] & r[0], r[2] | (d[0] & r[1])});
			rd_chk(CFG, d & 32'h0000_00d9);
		end
		for (i = 0; i < 6; i++)
		begin
			apb(1'h1, CFG, (i > 2) ? 32'h0000_0008 : 32'h0000_0000);
			far_st <= 2'(i % 3);
			repeat (3) @(posedge pclk);
			rd_chk(CTL, ectl(i % 3 == 0, i % 3 == 2, 4'h0));
		end
		far_st <= 2'h0;
		apb(1'h1, CFG, 32'h0000_0040);
		apb(1'h1, CTL, 32'h0000_0014);
		#1 chk({line_drive, line_oe, oe_monitor_n}, 5'h12);
		repeat (2) @(posedge pclk);
		rd_chk(CTL, ectl(1'h0, 1'h1, 4'h5));
		apb(1'h1, CTL, 32'h0000_0004);
		#1 chk({line_drive, line_oe, oe_monitor_n}, 5'h06);
		apb(1'h1, CFG, 32'h0000_0000);
		#1 chk({line_drive, line_oe, oe_monitor_n}, 5'h07);
		apb(1'h1, CTL, 32'h0000_0000);
		repeat (2) @(posedge pclk);
		#1 chk({line_drive, line_oe}, 4'h0);
		apb(1'h1, CTL, 32'h0000_0020);
		#1 chk(token_proc_en, 1'h0);
		apb(1'h1, CTL, 32'h0000_0000);
		#1 chk(token_proc_en, 1'h1);
		setup_token_rx <= 1'h1;
		@(posedge pclk);
		setup_token_rx <= 1'h0;
		rd_chk(CTL, ectl(1'h1, 1'h0, 4'h8));
		apb(1'h1, CTL, 32'h0000_0008);
		pulses(n);
		chk(n, 1);
		chk(host_mode, 1'h1);
		// Software confirms busy is clear before a token goes out
		rd_chk(CTL, ectl(1'h1, 1'h0, 4'h2));
		token_start <= 1'h1;
		@(posedge pclk);
		token_start <= 1'h0;
		rd_chk(CTL, ectl(1'h1, 1'h0, 4'ha));
		token_done <= 1'h1;
		@(posedge pclk);
		token_done <= 1'h0;
		apb(1'h1, CTL, 32'h0000_0028);
		rd_chk(CTL, ectl(1'h1, 1'h0, 4'h2));
		// Resume hold kept short: full wake-up time would dwarf the run
		apb(1'h1, CTL, 32'h0000_000c);
		apb(1'h1, CTL, 32'h0000_0008);
		span(2, n);
		chk(n, `UCC_EOP_SE0_CYC);
		span(1, n);
		chk(n, `UCC_EOP_J_CYC);
		apb(1'h1, CTL, 32'h0000_0000);
		pulses(n);
		chk(n, 1);
		chk(host_mode, 1'h0);
		// Mid-run reset must drop every written control
		apb(1'h1, CFG, 32'h0000_00d9);
		rd_chk(CFG, 32'h0000_00d9);
		presetn <= 1'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		repeat (3) @(posedge pclk);
		rd_chk(CFG, 32'h0000_0000);
		rd_chk(CTL, 32'h0000_0080);
		end_sim;
	end
endmodule
